// *** design/dfp_fifo2.sv ***
// two-entry buffer with valid/ready on both sides, head word registered
`timescale 1ns/1ps
`default_nettype none

module dfp_fifo2 #(
  parameter int W = 32
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_in_valid,
  output logic              o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output logic              o_out_valid,
  input  wire logic         i_out_ready,
  output logic      [W-1:0] o_out_data
);

  logic [W-1:0] head_q;
  logic [W-1:0] tail_q;
  logic         head_v_q;
  logic         tail_v_q;
  wire          push = i_in_valid & ~tail_v_q;
  wire          pop  = head_v_q & i_out_ready;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      head_q   <= '0;
      tail_q   <= '0;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end
    else
    begin
      if (pop)
      begin
        head_q   <= tail_v_q ? tail_q : i_in_data;
        head_v_q <= tail_v_q | push;
        tail_q   <= i_in_data;
        tail_v_q <= tail_v_q & push;
      end
      else if (push && !head_v_q)
      begin
        head_q   <= i_in_data;
        head_v_q <= 1'b1;
      end
      else if (push)
      begin
        tail_q   <= i_in_data;
        tail_v_q <= 1'b1;
      end
    end
  end

  // full only when both entries hold a word
  assign o_in_ready  = ~tail_v_q;
  assign o_out_valid = head_v_q;
  assign o_out_data  = head_q;

endmodule
`default_nettype wire

// *** design/dfp_port.sv ***
// data input port: data clock, sample clock phase, frame strobe, capture
`timescale 1ns/1ps
`default_nettype none
`include "dfp_map.svh"

module dfp_port (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wr_data,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  output logic      [7:0]  o_rd_data,
  input  wire logic        i_if_sel_ctrl,
  input  wire logic        i_if_sel_bus,
  input  wire logic [31:0] i_data,
  output logic             o_data_clock_out,
  output logic             o_frame_strobe,
  output logic             o_src_hold,
  output logic      [31:0] o_word,
  output logic             o_word_valid,
  input  wire logic        i_word_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic        rst_n;
  logic [1:0]  sel_s;
  logic [31:0] data_s;

  dfp_sync2 #(.W(1)) u_rst_sync (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_d     (1'b1),
    .o_q     (rst_n)
  );

  dfp_sync2 #(.W(2)) u_sel_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_d     ({i_if_sel_ctrl, i_if_sel_bus}),
    .o_q     (sel_s)
  );

  // data pins are sampled through two flops, so capture lags the pins by 2
  dfp_sync2 #(.W(32)) u_data_sync (
    .i_clk   (i_clk),
    .i_rst_n (rst_n),
    .i_d     (i_data),
    .o_q     (data_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic       inv_q;
  logic [2:0] div_q;
  logic [3:0] phase_q;
  logic [1:0] width_q;
  logic       chan_q;
  logic       en_q;
  logic [2:0] lat_q;
  logic [7:0] need_q;
  logic [7:0] avail_q;
  logic       err_q;
  logic       ovf_q;
  logic [7:0] rd_data_q;
  dfp_pkg::dfp_state_t state_q;
  dfp_pkg::dfp_state_t state_d;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] t);
    hit = (a == t);
  endfunction

  wire wr_inv   = i_wr_en & hit(i_addr, `DFP_ADDR_INV);
  wire wr_div   = i_wr_en & hit(i_addr, `DFP_ADDR_DIV);
  wire wr_phz   = i_wr_en & hit(i_addr, `DFP_ADDR_PHZ);
  wire wr_ctrl  = i_wr_en & hit(i_addr, `DFP_ADDR_CTRL);
  wire wr_need  = i_wr_en & hit(i_addr, `DFP_ADDR_NEED);
  wire wr_avail = i_wr_en & hit(i_addr, `DFP_ADDR_AVAIL);
  wire wr_stat  = i_wr_en & hit(i_addr, `DFP_ADDR_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // interface selection and data clock timing

  // straps that disagree select neither interface and stop capture
  wire is_cmos = sel_s[1] & sel_s[0];
  wire is_lvds = ~sel_s[1] & ~sel_s[0];
  wire is_ddr  = is_lvds & (width_q == dfp_pkg::DFP_W32);

  // divider 0 is treated as 1 so the clock never stops
  wire [2:0] div_eff = (div_q == 3'h0) ? `DFP_DIV_RST : div_q;
  wire [6:0] period  = {div_eff, 4'h0};
  wire [6:0] half    = {1'b0, div_eff, 3'h0};
  // one phase step is one sixteenth of the period, i.e. div_eff clocks
  wire [6:0] off     = {3'h0, phase_q} * {4'h0, div_eff};
  wire [7:0] fall_raw = {1'b0, off} + {1'b0, half};
  wire [7:0] fall_wrap = fall_raw - {1'b0, period};
  wire [6:0] fall_pos = (fall_raw >= {1'b0, period}) ? fall_wrap[6:0]
                                                      : fall_raw[6:0];
  wire [6:0] rise_pos = inv_q ? half : 7'h00;

  logic [6:0] cnt_q;
  logic       dco_q;
  wire        cnt_wrap = (cnt_q >= period - 7'h01);
  wire        dco_edge = (cnt_q == rise_pos);
  wire        dsc_rise = (cnt_q == off);
  wire        dsc_fall = (cnt_q == fall_pos);
  wire        dco_lvl  = (cnt_q < half) ^ inv_q;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 7'h00;
      dco_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_wrap ? 7'h00 : cnt_q + 7'h01;
      dco_q <= dco_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture into the buffer

  function automatic logic [31:0] width_mask(input logic [1:0] w);
    case (w)
      dfp_pkg::DFP_W4:  width_mask = 32'h0000000F;
      dfp_pkg::DFP_W8:  width_mask = 32'h000000FF;
      dfp_pkg::DFP_W16: width_mask = 32'h0000FFFF;
      default:          width_mask = 32'hFFFFFFFF;
    endcase
  endfunction

  wire cap_cmos = is_cmos & dsc_rise;
  wire cap_lvds = is_lvds & (dsc_fall | (is_ddr & dsc_rise));
  wire cap      = en_q & (cap_cmos | cap_lvds);
  wire [31:0] cap_word = data_s & width_mask(width_q);
  wire        buf_ready;

  dfp_fifo2 #(.W(32)) u_buf (
    .i_clk       (i_clk),
    .i_rst_n     (rst_n),
    .i_in_valid  (cap),
    .o_in_ready  (buf_ready),
    .i_in_data   (cap_word),
    .o_out_valid (o_word_valid),
    .i_out_ready (i_word_ready),
    .o_out_data  (o_word)
  );

  // the pin-side source cannot be paused mid word; hold asks it to wait
  assign o_src_hold = ~buf_ready;
  wire   ovf_set    = cap & ~buf_ready;

  ////////////////////////////////////////////////////////////////////////////
  // frame strobe sequencer

  wire [9:0] budget_need = {2'h0, need_q} + {7'h00, lat_q} + `DFP_LAT_MARGIN;
  wire budget_ok = ~chan_q | ({2'h0, avail_q} >= budget_need);
  wire runnable  = en_q & (avail_q != 8'h00);
  wire err_set   = runnable & ~budget_ok;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dfp_pkg::DFP_ST_IDLE:
        if (runnable)
          state_d = budget_ok ? dfp_pkg::DFP_ST_RUN : dfp_pkg::DFP_ST_HOLD;
      dfp_pkg::DFP_ST_RUN:
        if (!runnable)
          state_d = dfp_pkg::DFP_ST_IDLE;
        else if (!budget_ok)
          state_d = dfp_pkg::DFP_ST_HOLD;
      dfp_pkg::DFP_ST_HOLD:
        if (!runnable || budget_ok)
          state_d = dfp_pkg::DFP_ST_IDLE;
      default:
        state_d = dfp_pkg::DFP_ST_IDLE;
    endcase
  end

  logic [7:0] fcnt_q;
  logic       fs_q;
  wire        run = (state_q == dfp_pkg::DFP_ST_RUN);

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= dfp_pkg::DFP_ST_IDLE;
      fcnt_q  <= 8'h00;
      fs_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (!run)
      begin
        fcnt_q <= 8'h00;
        if (dco_edge)
          fs_q <= 1'b0;
      end
      else if (dco_edge)
      begin
        // strobe is high for one data clock period, launched on its rise
        fs_q   <= (fcnt_q == 8'h00);
        fcnt_q <= (fcnt_q == 8'h00) ? avail_q - 8'h01 : fcnt_q - 8'h01;
      end
    end
  end

  assign o_data_clock_out = dco_q;
  assign o_frame_strobe   = fs_q;

  ////////////////////////////////////////////////////////////////////////////
  // register writes and reads

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      inv_q   <= 1'b0;
      div_q   <= `DFP_DIV_RST;
      phase_q <= `DFP_PHZ_RST;
      width_q <= dfp_pkg::DFP_W32;
      chan_q  <= 1'b0;
      en_q    <= 1'b0;
      lat_q   <= 3'h0;
      need_q  <= `DFP_NEED_RST;
      avail_q <= `DFP_AVAIL_RST;
      err_q   <= 1'b0;
      ovf_q   <= 1'b0;
    end
    else
    begin
      if (wr_inv)
        inv_q <= i_wr_data[`DFP_INV_BIT];
      if (wr_div)
        div_q <= i_wr_data[`DFP_DIV_MSB:`DFP_DIV_LSB];
      if (wr_phz)
        phase_q <= i_wr_data[`DFP_PHZ_MSB:`DFP_PHZ_LSB];
      if (wr_ctrl)
      begin
        width_q <= i_wr_data[`DFP_WID_MSB:`DFP_WID_LSB];
        chan_q  <= i_wr_data[`DFP_CHAN_BIT];
        en_q    <= i_wr_data[`DFP_EN_BIT];
        lat_q   <= i_wr_data[`DFP_LAT_MSB:`DFP_LAT_LSB];
      end
      if (wr_need)
        need_q <= i_wr_data;
      if (wr_avail)
        avail_q <= i_wr_data;
      // a new event in the clearing cycle keeps its flag
      err_q <= err_set | (err_q & ~(wr_stat & i_wr_data[`DFP_ERR_BIT]));
      ovf_q <= ovf_set | (ovf_q & ~(wr_stat & i_wr_data[`DFP_OVF_BIT]));
    end
  end

  wire [7:0] rd_stat = {2'h0, state_q, is_ddr, is_cmos, ovf_q, err_q};
  wire [7:0] rd_mux =
    hit(i_addr, `DFP_ADDR_INV)   ? {3'h0, inv_q, 4'h0}         :
    hit(i_addr, `DFP_ADDR_DIV)   ? {1'b0, div_q, 4'h0}         :
    hit(i_addr, `DFP_ADDR_PHZ)   ? {phase_q, 4'h0}             :
    hit(i_addr, `DFP_ADDR_CTRL)  ? {1'b0, lat_q, en_q, chan_q, width_q} :
    hit(i_addr, `DFP_ADDR_NEED)  ? need_q                      :
    hit(i_addr, `DFP_ADDR_AVAIL) ? avail_q                     :
    hit(i_addr, `DFP_ADDR_STAT)  ? rd_stat                     : 8'h00;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data_q <= 8'h00;
    else
      rd_data_q <= i_rd_en ? rd_mux : 8'h00;
  end

  assign o_rd_data = rd_data_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks: helper counters measure each data clock period

  logic [7:0] age_q;
  logic [13:0] cfg_prev_q;
  logic [6:0] per_cnt_q;
  logic [1:0] capn_q;
  logic       dco_prev_q;
  wire [13:0] cfg = {inv_q, div_q, phase_q, width_q, en_q, sel_s, chan_q};
  wire        rose_dco = dco_q & ~dco_prev_q;
  wire        settled  = (age_q == `DFP_AGE_MAX);
  wire [1:0]  cap_exp  = ~en_q ? 2'h0 : is_ddr ? 2'h2 :
                         (is_cmos | is_lvds) ? 2'h1 : 2'h0;

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      age_q      <= 8'h00;
      dco_prev_q <= 1'b0;
      cfg_prev_q <= 14'h0000;
      per_cnt_q  <= 7'h00;
      capn_q     <= 2'h0;
    end
    else
    begin
      cfg_prev_q <= cfg;
      dco_prev_q <= dco_q;
      age_q      <= (cfg != cfg_prev_q) ? 8'h00
                  : (settled ? age_q : age_q + 8'h01);
      per_cnt_q  <= rose_dco ? 7'h01 : per_cnt_q + 7'h01;
      capn_q     <= rose_dco ? {1'b0, cap} : capn_q + {1'b0, cap};
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!rst_n);

  a_dco_period: assert property (
    rose_dco && settled |-> per_cnt_q == period)
    else $error("data clock period differs from sixteen steps of divider");
  a_lvds_rate: assert property (
    rose_dco && settled && is_lvds |-> per_cnt_q == period)
    else $error("lvds data clock period differs from sixteen steps");
  a_capture_count: assert property (
    rose_dco && settled |-> capn_q == cap_exp)
    else $error("captures per data clock period do not match mode");
  a_sdr_fall_only: assert property (
    cap && is_lvds && !is_ddr |-> dsc_fall && !dsc_rise)
    else $error("single rate lvds captured on sample clock rise");
  a_cmos_rise: assert property (
    cap && is_cmos |-> dsc_rise && !dsc_fall)
    else $error("cmos capture not at sample clock rise");
  a_phase_reg: assert property (
    i_rd_en && hit(i_addr, `DFP_ADDR_PHZ) |=>
      o_rd_data[`DFP_PHZ_MSB:`DFP_PHZ_LSB] == $past(phase_q))
    else $error("phase field read back wrong");
  a_phase_step: assert property (
    dsc_rise && settled && !inv_q |-> cnt_q == {3'h0, phase_q} * {4'h0, div_eff})
    else $error("sample point not at phase steps of one sixteenth");
  a_div_write: assert property (
    wr_div |=> div_q == $past(i_wr_data[`DFP_DIV_MSB:`DFP_DIV_LSB]))
    else $error("divider field not stored");
  a_fs_on_dco: assert property (fs_q && !$past(fs_q) |-> rose_dco)
    else $error("frame strobe rose away from data clock rise");
  // three cycles: a strobe already launched from the run state may still rise
  a_budget_block: assert property (
    (settled && !budget_ok) [*3] |-> !(fs_q && !$past(fs_q)))
    else $error("frame strobe issued with too small a cycle budget");
  a_err_sticky: assert property (err_set |=> err_q)
    else $error("budget error flag lost on set");

  c_ddr_capture: cover property (cap && is_ddr && dsc_rise);
  c_frame_run: cover property (fs_q && !$past(fs_q) && chan_q);
  c_buffer_full: cover property (o_src_hold && cap);

endmodule
`default_nettype wire

// *** design/dfp_sync2.sv ***
// two-flop synchroniser, also used as the reset release stage
`timescale 1ns/1ps
`default_nettype none

module dfp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule
`default_nettype wire

// *** inc/dfp_map.svh ***
// register map, field positions, reset values and timing counts of the port
//
// How it works
// - channelizer frames need available cycles >= interface cycles + latency + 2.
// - cmos mode drives a data clock at converter clock / 16 for divider 1.
// - cmos data is taken on the rising edge of the internal sample clock.
// - sample clock matches data clock rate; phase set by 0x23 bits 7..4.
// - each phase step moves the capture point by one sixteenth period.
// - lvds single rate takes one word on the sample clock falling edge.
// - lvds uses both sample edges only at 32-bit width.
// - lvds data clock is converter clock / 16 for divider 1.
// - invert bit at 0x20 bit 4, divider at 0x22 bits 6..4.
// - each frame strobe rise is launched from a data clock rise.
`ifndef DFP_MAP_SVH
`define DFP_MAP_SVH

`define DFP_ADDR_INV      8'h20
`define DFP_ADDR_DIV      8'h22
`define DFP_ADDR_PHZ      8'h23
`define DFP_ADDR_CTRL     8'h24
`define DFP_ADDR_NEED     8'h25
`define DFP_ADDR_AVAIL    8'h26
`define DFP_ADDR_STAT     8'h27

`define DFP_INV_BIT       4
`define DFP_DIV_MSB       6
`define DFP_DIV_LSB       4
`define DFP_PHZ_MSB       7
`define DFP_PHZ_LSB       4
`define DFP_WID_MSB       1
`define DFP_WID_LSB       0
`define DFP_CHAN_BIT      2
`define DFP_EN_BIT        3
`define DFP_LAT_MSB       6
`define DFP_LAT_LSB       4
`define DFP_ERR_BIT       0
`define DFP_OVF_BIT       1

`define DFP_DIV_RST       3'h1
`define DFP_PHZ_RST       4'h0
`define DFP_NEED_RST      8'h08
`define DFP_AVAIL_RST     8'h10
`define DFP_LAT_MARGIN    10'h002
`define DFP_AGE_MAX       8'hFF

`endif

// *** inc/dfp_pkg.sv ***
// types shared by the data input port
package dfp_pkg;

  typedef enum logic [1:0]
  {
    DFP_ST_IDLE = 2'h0,
    DFP_ST_RUN  = 2'h1,
    DFP_ST_HOLD = 2'h3
  } dfp_state_t;

  typedef enum logic [1:0]
  {
    DFP_W4  = 2'h0,
    DFP_W8  = 2'h1,
    DFP_W16 = 2'h2,
    DFP_W32 = 2'h3
  } dfp_width_t;

endpackage

// *** verification/dfp_port_tb.sv ***
// self-checking bench for the data input port
`timescale 1ns/1ps
`default_nettype none

module dfp_port_tb;
  logic        i_clk, i_rst_n, i_wr_en, i_rd_en, i_word_ready;
  logic [7:0]  i_addr, i_wr_data, o_rd_data, frames;
  logic        sel_ctrl, sel_bus, data_clock_out, fs, hold, o_word_valid, lvds, mix;
  logic [31:0] bus, o_word, base, exp_word;
  logic [15:0] rd_q[$];
  logic [15:0] note;
  logic        chk_word, rd_d, fs_d, dco_d;
  logic [2:0]  dv;
  int          miscompares, n_compared, pops, seed, k, n, f, w;
  int          o0, o1, o2, o3;

  dfp_port u_dfp_port (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en),
    .o_rd_data(o_rd_data), .i_if_sel_ctrl(sel_ctrl), .i_if_sel_bus(sel_bus),
    .i_data(bus), .o_data_clock_out(data_clock_out), .o_frame_strobe(fs),
    .o_src_hold(hold), .o_word(o_word), .o_word_valid(o_word_valid),
    .i_word_ready(i_word_ready)
  );

  dfp_src_model u_dfp_src_model (
    .i_clk(i_clk), .i_dco(data_clock_out), .i_fs(fs), .i_lvds(lvds), .i_mix(mix),
    .i_base(base),
    .o_data(bus), .o_sel_ctrl(sel_ctrl), .o_sel_bus(sel_bus),
    .o_frames(frames)
  );

  always #2 i_clk = ~i_clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr_en   <= 1'b1;
    i_addr    <= a;
    i_wr_data <= d;
    @(posedge i_clk);
    i_wr_en <= 1'b0;
  endtask

  // the expected value and its mask are noted for the read watcher
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    @(posedge i_clk);
    i_rd_en <= 1'b1;
    i_addr  <= a;
    rd_q.push_back({m, e});
    @(posedge i_clk);
    i_rd_en <= 1'b0;
  endtask

  function automatic logic ev(input int s);
    return (s == 0) ? (data_clock_out && !dco_d) : (s == 1) ? (fs && !fs_d) : o_word_valid;
  endfunction

  // k counts the edges up to and including the one that shows the event
  task automatic wait_ev(input int s, output int k);
    k = 1;
    @(posedge i_clk);
    while (!ev(s) && k < 3000)
    begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 3000)
    begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic meas(output int o);
    repeat (64) @(posedge i_clk);
    wait_ev(0, o);
    wait_ev(2, o);
  endtask

  ////////////////////////////////////////////////////////////////////////
  always @(posedge i_clk)
  begin
    rd_d  <= i_rd_en;
    fs_d  <= fs;
    dco_d <= data_clock_out;
    if (rd_d)
    begin
      note = rd_q.pop_front();
      check({24'h0, o_rd_data & note[15:8]}, {24'h0, note[7:0]}, "read");
    end
    if (fs && !fs_d)
      check({31'h0, data_clock_out && !dco_d}, 32'h1, "strobe edge");
    if (o_word_valid && i_word_ready)
    begin
      pops++;
      if (chk_word)
        check(o_word, exp_word, "word");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    i_addr = 8'h0;
    i_wr_data = 8'h0;
    i_wr_en = 1'b0;
    i_rd_en = 1'b0;
    i_word_ready = 1'b1;
    lvds = 1'b0;
    mix = 1'b0;
    base = 32'h0;
    exp_word = 32'h0;
    {chk_word, rd_d, fs_d, dco_d} = 4'h0;
    {miscompares, n_compared, pops} = 0;
    seed = 32'hEE58;
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    rd(8'h20, 8'h00, 8'h10);
    rd(8'h22, 8'h10, 8'h70);
    rd(8'h23, 8'h00, 8'hF0);
    rd(8'h24, 8'h03, 8'h7F);
    rd(8'h25, 8'h08, 8'hFF);
    rd(8'h26, 8'h10, 8'hFF);
    rd(8'h30, 8'h00, 8'hFF);
    wr(8'h23, 8'hA0);
    rd(8'h23, 8'hA0, 8'hF0);
    wr(8'h20, 8'h10);
    rd(8'h20, 8'h10, 8'h10);
    wr(8'h20, 8'h00);
    // divider 0 is taken as 1; 7 is the top of the field
    for (int d = 0; d < 4; d++)
    begin
      dv = (d == 3) ? 3'h7 : 3'(d);
      wr(8'h22, {1'b0, dv, 4'h0});
      wait_ev(0, k);
      wait_ev(0, k);
      check(32'(k), 32'(16 * ((dv == 3'h0) ? 1 : dv)), "period");
    end
    wr(8'h22, 8'h10);
    // every width, first on the cmos straps, then on lvds
    for (int m = 0; m < 8; m++)
    begin
      w = m % 4;
      lvds <= (m > 3);
      base <= $random(seed);
      i_word_ready <= 1'b1;
      wr(8'h24, 8'h08 | 8'(w));
      repeat (80) @(posedge i_clk);
      exp_word = base & ((w == 3) ? 32'hFFFFFFFF : (32'h1 << (4 << w)) - 32'h1);
      @(negedge i_clk);
      chk_word = 1'b1;
      n = pops;
      repeat (128) @(negedge i_clk);
      check(32'(pops - n), (m == 7) ? 32'h10 : 32'h8, "rate");
      rd(8'h27, {4'h0, m == 7, m < 4, 2'h0}, 8'h0C);
      repeat (150)
      begin
        @(posedge i_clk);
        i_word_ready <= 1'($random(seed));
      end
      @(negedge i_clk);
      chk_word = 1'b0;
    end
    // disagreeing straps select no interface and stop capture
    @(posedge i_clk);
    i_word_ready <= 1'b1;
    mix <= 1'b1;
    repeat (80) @(posedge i_clk);
    n = pops;
    repeat (64) @(posedge i_clk);
    check(32'(pops - n), 32'h0, "mixed straps");
    rd(8'h27, 8'h00, 8'h0C);
    // capture point against the data clock rise
    mix <= 1'b0;
    lvds <= 1'b0;
    wr(8'h24, 8'h0A);
    wr(8'h23, 8'h00);
    meas(o0);
    wr(8'h20, 8'h10);
    meas(o3);
    wr(8'h20, 8'h00);
    wr(8'h23, 8'h50);
    meas(o1);
    lvds <= 1'b1;
    wr(8'h23, 8'h00);
    meas(o2);
    check(32'((o1 - o0 + 16) % 16), 32'h5, "phase step");
    check(32'((o2 - o0 + 16) % 16), 32'h8, "sdr edge");
    check(32'((o3 - o0 + 16) % 16), 32'h8, "inverted clock");
    // fill the buffer with the consumer stalled, then drain it
    lvds <= 1'b0;
    wr(8'h24, 8'h0B);
    wr(8'h27, 8'h03);
    rd(8'h27, 8'h00, 8'h03);
    i_word_ready <= 1'b0;
    repeat (48) @(posedge i_clk);
    check({31'h0, hold}, 32'h1, "hold when full");
    rd(8'h27, 8'h02, 8'h02);
    wr(8'h24, 8'h03);
    repeat (40) @(negedge i_clk);
    exp_word = base;
    chk_word = 1'b1;
    n = pops;
    @(posedge i_clk);
    i_word_ready <= 1'b1;
    repeat (10) @(negedge i_clk);
    check(32'(pops - n), 32'h2, "drain count");
    check({31'h0, o_word_valid}, 32'h0, "empty");
    chk_word = 1'b0;
    // strobe spacing outside channelizer mode
    wr(8'h26, 8'h04);
    wr(8'h24, 8'h0B);
    wait_ev(1, k);
    f = frames;
    wait_ev(1, k);
    check(32'(k), 32'h40, "frame gap");
    check(32'(frames - f), 32'h1, "frames");
    // channelizer budget: 8 + 7 + 2 exceeds 16, 8 + 6 + 2 meets it
    wr(8'h26, 8'h10);
    wr(8'h24, 8'h7F);
    repeat (8) @(posedge i_clk);
    rd(8'h27, 8'h31, 8'h31);
    f = frames;
    repeat (300) @(posedge i_clk);
    check(32'(frames - f), 32'h0, "no frames");
    wr(8'h24, 8'h6F);
    wr(8'h27, 8'h01);
    rd(8'h27, 8'h10, 8'h31);
    wait_ev(1, k);
    wait_ev(1, k);
    check(32'(k), 32'h100, "budget gap");
    repeat (4) @(posedge i_clk);
    final_report();
  end
endmodule
`default_nettype wire

// *** verification/dfp_src_model.sv ***
// behavioural sample source on the far side of the data input port
`timescale 1ns/1ps
`default_nettype none

module dfp_src_model (
  input  wire logic        i_clk,
  input  wire logic        i_dco,
  input  wire logic        i_fs,
  input  wire logic        i_lvds,
  input  wire logic        i_mix,
  input  wire logic [31:0] i_base,
  output logic      [31:0] o_data,
  output logic             o_sel_ctrl,
  output logic             o_sel_bus,
  output logic      [7:0]  o_frames
);
  logic dco_q;
  logic fs_q;

  // straps move together unless mix asks for a disagreeing pair
  assign o_sel_ctrl = !i_lvds;
  assign o_sel_bus  = !i_lvds ^ i_mix;

  initial
  begin
    o_data   = 32'h0;
    o_frames = 8'h0;
    dco_q    = 1'b0;
    fs_q     = 1'b0;
  end

  always @(posedge i_clk)
  begin
    dco_q <= i_dco;
    fs_q  <= i_fs;
    // launched on the clock rise: the word is settled at both sample edges
    if (i_dco && !dco_q)
      o_data <= i_base;
    // a new frame starts on the cycle after the strobe is seen
    if (i_fs && !fs_q)
      o_frames <= o_frames + 8'h01;
  end
endmodule
`default_nettype wire
